// >>> hdl/phiwd_cfg_end.sv
`timescale 1ns/1ns
`include "phiwd_map.svh"

// ----------------------------------------------------------------------
// Configuring controller: APB registers and window programming.
// ----------------------------------------------------------------------
module phiwd_cfg_end (
    input  wire logic        clk,        // 10 MHz clock.
    input  wire logic        rst,        // Synchronous reset, high.
    phiwd_link_if.cfg        link,       // Configuration carrier.
    input  wire logic        psel,       // APB select.
    input  wire logic        penable,    // APB enable.
    input  wire logic        pwrite,     // APB write.
    input  wire logic [7:0]  paddr,      // APB byte address.
    input  wire logic [31:0] pwdata,     // APB write data.
    output logic [31:0]      prdata,     // APB read data.
    output logic             pready,     // APB ready.
    output logic             pslverr,    // APB error, unmapped offset.
    output logic             cfg_busy,   // Programming in progress.
    output logic             cfg_locked  // Window programmed.
);
    phiwd_pkg::phiwd_ctl_s q;     // Registered state.
    phiwd_pkg::phiwd_ctl_s d;     // Next state.
    logic                  wr_en; // APB write takes effect.
    logic                  go;    // Commit requested.
    logic                  bad;   // Window would leave the allowed span.

    // Mapped offsets, used for the error answer only; the read mux decodes paddr itself.
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == `PHIWD_A_CTRL) || (a == `PHIWD_A_BASE) ||
                    (a == `PHIWD_A_LIMIT) || (a == `PHIWD_A_RANGE) ||
                    (a == `PHIWD_A_STAT);
    endfunction

    assign wr_en = psel && penable && q.pready && pwrite;
    assign go    = wr_en && (paddr == `PHIWD_A_CTRL) && pwdata[`PHIWD_CTRL_GO];
    // An enabled, ordered window must stay inside the global span.
    assign bad   = q.base[`PHIWD_EN_BIT] && (q.base[11:0] <= q.limit[11:0])
                && ((q.base[11:0] < q.rng_lo) || (q.limit[11:0] > q.rng_hi)); // see [R9] see [R11]

    // ------------------------------------------------------------------
    // Next-state logic.
    // ------------------------------------------------------------------
    always_comb begin
        d = q;
        // APB: one wait-free access phase; ready rises for it alone.
        if (psel && !penable && !q.pready) begin
            d.pready  = 1'b1;
            d.pslverr = !is_mapped(paddr);
            if (paddr == `PHIWD_A_BASE) begin
                d.prdata = {16'h0000, q.base};
            end else if (paddr == `PHIWD_A_LIMIT) begin
                d.prdata = {16'h0000, q.limit};
            end else if (paddr == `PHIWD_A_RANGE) begin
                d.prdata = {4'h0, q.rng_hi, 4'h0, q.rng_lo};
            end else if (paddr == `PHIWD_A_STAT) begin
                d.prdata = {28'h0000000, q.refused, q.locked, q.done,
                            (q.state != phiwd_pkg::PHIWD_C_IDLE)};
            end else begin
                d.prdata = 32'h00000000;
            end
        end else if (q.pready) begin
            d.pready  = 1'b0;
            d.pslverr = 1'b0;
        end
        // Staged images; the hub only changes on a commit.
        if (wr_en && paddr == `PHIWD_A_BASE) begin
            d.base = pwdata[15:0] & `PHIWD_LOWER_WMASK;
        end
        if (wr_en && paddr == `PHIWD_A_LIMIT) begin
            d.limit = pwdata[15:0] & `PHIWD_UPPER_WMASK;
        end
        if (wr_en && paddr == `PHIWD_A_RANGE) begin
            d.rng_lo = pwdata[11:0];
            d.rng_hi = pwdata[27:16];
        end
        // Clear first, so that a refusal in the same cycle still sticks.
        if (wr_en && paddr == `PHIWD_A_CTRL && pwdata[`PHIWD_CTRL_CLR]) begin
            d.refused = 1'b0;
        end
        unique case (q.state)
            phiwd_pkg::PHIWD_C_IDLE: begin
                if (go) begin
                    if (q.locked || bad) begin
                        d.refused = 1'b1;               // see [R10] see [R9]
                    end else begin
                        // Upper first: the enable in the lower word must
                        // never meet a stale limit.
                        d.state = phiwd_pkg::PHIWD_C_WUP;
                        d.req   = 1'b1;
                        d.we    = 1'b1;
                        d.addr  = `PHIWD_UPPER_OFS;
                        d.wdata = q.limit;
                        d.done  = 1'b0;
                    end
                end
            end
            phiwd_pkg::PHIWD_C_WUP: begin
                if (link.cfg_ack) begin
                    d.state = phiwd_pkg::PHIWD_C_WLOW;
                    d.addr  = `PHIWD_LOWER_OFS;
                    d.wdata = q.base;
                end
            end
            phiwd_pkg::PHIWD_C_WLOW: begin
                if (link.cfg_ack) begin
                    d.state  = phiwd_pkg::PHIWD_C_IDLE;
                    d.req    = 1'b0;
                    d.we     = 1'b0;
                    d.done   = 1'b1;
                    d.locked = 1'b1;                     // see [R10]
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State register.
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            q         <= '0;
            q.state   <= phiwd_pkg::PHIWD_C_IDLE;
            q.base    <= `PHIWD_LOWER_RST;
            q.limit   <= `PHIWD_UPPER_RST;
            q.rng_lo  <= `PHIWD_RANGE_LO_RST;
            q.rng_hi  <= `PHIWD_RANGE_HI_RST;
        end else begin
            q <= d;
        end
    end

    // Every hub on the carrier sees the same write, so the primary and
    // the peer copy can only ever hold one value.
    assign link.cfg_req   = q.req;                       // see [R8]
    assign link.cfg_we    = q.we;
    assign link.cfg_addr  = q.addr;
    assign link.cfg_wdata = q.wdata;                     // see [R8]
    assign prdata         = q.prdata;
    assign pready         = q.pready;
    assign pslverr        = q.pslverr;
    assign cfg_busy       = q.req;  // The request stands exactly while a commit runs.
    assign cfg_locked     = q.locked;
    // Sizing the window over every peer controller range stays a
    // software duty; the span register is the only guard offered here.
endmodule

// >>> hdl/phiwd_hub_end.sv
`timescale 1ns/1ns
`include "phiwd_map.svh"

// What the design must do
// [R1] Enabled window hits route to peer hub.
// [R2] Peer claims hits, primary forwards over link.
// [R3] Enable clear: window routes nothing.
// [R4] Base above limit disables the window.
// [R5] Lower bound: three nibbles, bits 14:12 zero.
// [R6] Upper bound: three nibbles, bits 15:12 zero.
// [R7] Window acts only in proxy strap mode.
// [R8] Both hub copies get identical values.
// [R9] Window consistent with global address ranges.
// [R10] Program once, never change afterwards.
// [R11] Window covers all peer controller ranges. Not checked here: only the span register guards the window.
// [R12] Compare bits 19:8, prefix fixed, ignore 7:0.

// ----------------------------------------------------------------------
// Hub end: window registers and outbound decode.
// ----------------------------------------------------------------------
module phiwd_hub_end (
    input  wire logic        clk,              // 10 MHz clock.
    input  wire logic        rst,              // Synchronous reset, high.
    phiwd_link_if.hub        link,             // Configuration carrier.
    input  wire logic [1:0]  strap_mode,       // Operating mode strap.
    input  wire logic        strap_is_peer,    // Strap: this is the peer hub.
    input  wire logic        txn_valid,        // Outbound memory request.
    input  wire logic [31:0] txn_addr,         // Its address.
    output logic             dec_valid,        // Decision pulse.
    output logic             dec_to_peer,      // Targets the peer hub.
    output logic             dec_claim_local,  // Claimed here.
    output logic             dec_forward_link, // Sent over the hub link.
    output logic             dec_pass,         // Outside the window.
    output logic             win_live          // Window is in force.
);
    // ------------------------------------------------------------------
    // State and its next value.
    // ------------------------------------------------------------------
    phiwd_pkg::phiwd_hub_s q;      // Registered state.
    phiwd_pkg::phiwd_hub_s d;      // Next state.
    logic                  m_live; // Window enabled, from the matcher.
    logic                  m_hit;  // Address hit, from the matcher.
    logic                  proxy;  // Hub runs in proxy mode.

    // Only the strapped proxy mode lets the window steer routing.
    assign proxy = (q.mode == phiwd_pkg::PHIWD_MODE_PROXY);  // see [R7]

    // ------------------------------------------------------------------
    // Hit test.
    // ------------------------------------------------------------------
    // The matcher sees the registers themselves, so a new setting is
    // in force from the cycle after the write.
    phiwd_win_match u_match (
        .addr  (txn_addr),
        .lower (q.lower),
        .upper (q.upper),
        .proxy (proxy),
        .live  (m_live),
        .hit   (m_hit)
    );

    // ------------------------------------------------------------------
    // Next-state logic.
    // ------------------------------------------------------------------
    // One process covers the configuration port and the decode path,
    // because both only read registered state and write disjoint fields.
    always_comb begin
        d        = q;
        d.ack    = 1'b0;
        d.dvalid = 1'b0;
        d.to_peer = 1'b0;
        d.claim  = 1'b0;
        d.fwd    = 1'b0;
        d.pass   = 1'b0;
        d.live   = m_live;

        // A request is taken once; while its answer stands the same
        // request is still held, and taking it again would repeat it.
        if (link.cfg_req && !q.ack) begin
            d.ack = 1'b1;
            if (link.cfg_addr == `PHIWD_LOWER_OFS) begin
                // Read returns the value held before this access.
                d.rdata = q.lower;
                if (link.cfg_we) begin
                    // Reserved bits 14:12 stay zero.
                    d.lower = link.cfg_wdata & `PHIWD_LOWER_WMASK;  // see [R5]
                end
            end else if (link.cfg_addr == `PHIWD_UPPER_OFS) begin
                d.rdata = q.upper;
                if (link.cfg_we) begin
                    // Reserved bits 15:12 stay zero.
                    d.upper = link.cfg_wdata & `PHIWD_UPPER_WMASK;  // see [R6]
                end
            end else begin
                // Unmapped offsets answer with zero and store nothing.
                d.rdata = 16'h0000;
            end
        end

        // Every outbound request gets exactly one decision, one cycle on.
        if (txn_valid) begin
            d.dvalid  = 1'b1;
            d.to_peer = m_hit;                   // see [R1] see [R3]
            d.claim   = m_hit & q.is_peer;       // see [R2]
            d.fwd     = m_hit & ~q.is_peer;      // see [R2]
            d.pass    = ~m_hit;
        end
    end

    // ------------------------------------------------------------------
    // State register.
    // ------------------------------------------------------------------
    // The reset is synchronous, so the straps are caught on the same
    // clocked edges that hold the reset and frozen from its release on.
    // Changing the straps later has no effect until the next reset.
    always_ff @(posedge clk) begin
        if (rst) begin
            q.lower   <= `PHIWD_LOWER_RST;
            q.upper   <= `PHIWD_UPPER_RST;
            q.mode    <= phiwd_pkg::phiwd_mode_e'(strap_mode);
            q.is_peer <= strap_is_peer;
            q.ack     <= 1'b0;
            q.rdata   <= 16'h0000;
            q.dvalid  <= 1'b0;
            q.to_peer <= 1'b0;
            q.claim   <= 1'b0;
            q.fwd     <= 1'b0;
            q.pass    <= 1'b0;
            q.live    <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, each straight from a flip-flop.
    // ------------------------------------------------------------------
    assign link.cfg_ack     = q.ack;
    assign link.cfg_rdata   = q.rdata;
    assign dec_valid        = q.dvalid;
    assign dec_to_peer      = q.to_peer;
    assign dec_claim_local  = q.claim;
    assign dec_forward_link = q.fwd;
    assign dec_pass         = q.pass;
    assign win_live         = q.live;

    // A limitation worth knowing: the decision is made on the address
    // alone; the caller must present only memory requests here, since
    // the window has no meaning for configuration or I/O cycles.
    // Decisions cannot stall, so no ready is offered back.
endmodule

// >>> hdl/phiwd_win_match.sv
`timescale 1ns/1ns
`include "phiwd_map.svh"

// ----------------------------------------------------------------------
// Window hit test, purely combinational.
// ----------------------------------------------------------------------
module phiwd_win_match (
    input  wire logic [31:0] addr,    // Outbound memory address.
    input  wire logic [15:0] lower,   // Lower bound register.
    input  wire logic [15:0] upper,   // Upper bound register.
    input  wire logic        proxy,   // Hub runs in dual-hub proxy mode.
    output logic             live,    // Window effectively enabled.
    output logic             hit      // Address falls in the window.
);
    logic [11:0] lo_nib;  // Address bits 19:8 of the base.
    logic [11:0] up_nib;  // Address bits 19:8 of the limit.

    assign lo_nib = lower[`PHIWD_NIB_MSB:0];
    assign up_nib = upper[`PHIWD_NIB_MSB:0];

    // Mode gate, enable bit and ordering of the bounds all must agree.
    assign live = proxy                            // see [R7]
                & lower[`PHIWD_EN_BIT]             // see [R1] see [R3]
                & (lo_nib <= up_nib);              // see [R4]

    // Upper prefix fixed, bits 19:8 inclusive, bits 7:0 ignored.
    assign hit = live
               & (addr[31:20] == `PHIWD_REGION)    // see [R12]
               & (addr[19:8] >= lo_nib)            // see [R12]
               & (addr[19:8] <= up_nib);           // see [R1]
endmodule

// >>> inc/phiwd_link_if.sv
`timescale 1ns/1ns

// ----------------------------------------------------------------------
// Configuration carrier between the controller and the hub.
// ----------------------------------------------------------------------
interface phiwd_link_if;
    logic        cfg_req;    // Request held until answered.
    logic        cfg_we;     // High for a write.
    logic [11:0] cfg_addr;   // Register offset.
    logic [15:0] cfg_wdata;  // Write data.
    logic        cfg_ack;    // One-cycle answer.
    logic [15:0] cfg_rdata;  // Read data, valid with the answer.

    // The hub answers requests.
    modport hub (
        input  cfg_req, cfg_we, cfg_addr, cfg_wdata,
        output cfg_ack, cfg_rdata
    );

    // The controller issues requests.
    modport cfg (
        output cfg_req, cfg_we, cfg_addr, cfg_wdata,
        input  cfg_ack, cfg_rdata
    );
endinterface

// >>> inc/phiwd_map.svh
`ifndef PHIWD_MAP_SVH
`define PHIWD_MAP_SVH

// ----------------------------------------------------------------------
// Hub-side window registers, reached over the configuration carrier.
// ----------------------------------------------------------------------
`define PHIWD_LOWER_OFS    12'h148
`define PHIWD_UPPER_OFS    12'h14a
`define PHIWD_LOWER_RST    16'h0000
`define PHIWD_UPPER_RST    16'h0000
`define PHIWD_LOWER_WMASK  16'h8fff
`define PHIWD_UPPER_WMASK  16'h0fff
`define PHIWD_EN_BIT       15
`define PHIWD_NIB_MSB      11
`define PHIWD_REGION       12'hfec

// ----------------------------------------------------------------------
// Controller registers on APB, one aligned word each.
// ----------------------------------------------------------------------
`define PHIWD_A_CTRL       8'h00
`define PHIWD_A_BASE       8'h04
`define PHIWD_A_LIMIT      8'h08
`define PHIWD_A_RANGE      8'h0c
`define PHIWD_A_STAT       8'h10
`define PHIWD_CTRL_GO      0
`define PHIWD_CTRL_CLR     1
`define PHIWD_RANGE_LO_RST 12'h000
`define PHIWD_RANGE_HI_RST 12'hfff

`endif

// >>> inc/phiwd_pkg.sv
package phiwd_pkg;

    // ------------------------------------------------------------------
    // Strap-selected operating modes of the hub.
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PHIWD_MODE_SINGLE  = 2'h0,
        PHIWD_MODE_PROXY   = 2'h1,
        PHIWD_MODE_OTHER_A = 2'h2,
        PHIWD_MODE_OTHER_B = 2'h3
    } phiwd_mode_e;

    // Controller sequence, Gray coded along idle, upper, lower.
    typedef enum logic [1:0] {
        PHIWD_C_IDLE = 2'h0,
        PHIWD_C_WUP  = 2'h1,
        PHIWD_C_WLOW = 2'h3
    } phiwd_cstate_e;

    // All state of the hub end.
    typedef struct packed {
        logic [15:0] lower;     // Lower bound register with enable.
        logic [15:0] upper;     // Upper bound register.
        phiwd_mode_e mode;      // Strap mode caught at reset.
        logic        is_peer;   // Strap: this hub is the peer hub.
        logic        ack;       // Configuration answer.
        logic [15:0] rdata;     // Configuration read data.
        logic        dvalid;    // Decision valid pulse.
        logic        to_peer;   // Transaction targets the peer hub.
        logic        claim;     // Claimed locally.
        logic        fwd;       // Forwarded over the hub link.
        logic        pass;      // Not in the window.
        logic        live;      // Window effectively enabled.
    } phiwd_hub_s;

    // All state of the configuring controller.
    typedef struct packed {
        phiwd_cstate_e state;   // Sequence state.
        logic [15:0]   base;    // Staged lower bound image.
        logic [15:0]   limit;   // Staged upper bound image.
        logic [11:0]   rng_lo;  // Allowed span, low end.
        logic [11:0]   rng_hi;  // Allowed span, high end.
        logic          locked;  // Window programmed once.
        logic          done;    // Last commit completed.
        logic          refused; // Sticky: a commit was refused.
        logic          req;     // Carrier request.
        logic          we;      // Carrier write.
        logic [11:0]   addr;    // Carrier offset.
        logic [15:0]   wdata;   // Carrier write data.
        logic          pready;  // APB ready.
        logic [31:0]   prdata;  // APB read data.
        logic          pslverr; // APB error.
    } phiwd_ctl_s;

endpackage

// >>> test/phiwd_link_sva.sv
`timescale 1ns/1ns
`include "phiwd_map.svh"

// ----------------------------------------------------------------------
// Carrier checks between the controller and the hub.
// ----------------------------------------------------------------------
module phiwd_link_sva (
    input wire logic        clk,       // Shared clock.
    input wire logic        rst,       // Synchronous reset, high.
    input wire logic        cfg_req,   // Request level.
    input wire logic        cfg_we,    // Write flag.
    input wire logic [11:0] cfg_addr,  // Register offset.
    input wire logic [15:0] cfg_wdata, // Write data.
    input wire logic        cfg_ack,   // One-cycle answer.
    input wire logic [15:0] cfg_rdata  // Read data.
);
    // One domain only, so clock and reset are given once for all.
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_ack_next; cfg_req && !cfg_ack |=> cfg_ack; endproperty
    a_ack_next: assert property (p_ack_next) else $error("Carrier answer late.");
    property p_ack_cause; cfg_ack |-> $past(cfg_req) && !$past(cfg_ack); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("Answer without request.");
    property p_ack_pulse; cfg_ack |=> !cfg_ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("Answer too long.");
    property p_hold;
        cfg_req && !cfg_ack |=> cfg_req && $stable(cfg_addr) && $stable(cfg_wdata)
            && $stable(cfg_we);
    endproperty
    a_hold: assert property (p_hold) else $error("Request changed early.");
    // Reserved bits must never reach the hub copies.
    property p_lo_resv; cfg_req && cfg_addr == `PHIWD_LOWER_OFS |-> cfg_wdata[14:12] == 3'h0;
    endproperty
    a_lo_resv: assert property (p_lo_resv) else $error("Lower reserved bits set.");
    property p_up_resv; cfg_req && cfg_addr == `PHIWD_UPPER_OFS |-> cfg_wdata[15:12] == 4'h0;
    endproperty
    a_up_resv: assert property (p_up_resv) else $error("Upper reserved bits set.");
    // Upper bound goes first so the enable lands on a complete window.
    property p_first; $rose(cfg_req) |-> cfg_we && cfg_addr == `PHIWD_UPPER_OFS; endproperty
    a_first: assert property (p_first) else $error("Commit not upper first.");
    property p_order;
        cfg_ack && cfg_addr == `PHIWD_UPPER_OFS |=> cfg_req && cfg_we
            && cfg_addr == `PHIWD_LOWER_OFS;
    endproperty
    a_order: assert property (p_order) else $error("Lower write missing.");
    property p_end; cfg_ack && cfg_addr == `PHIWD_LOWER_OFS |=> !cfg_req; endproperty
    a_end: assert property (p_end) else $error("Request after commit.");

    c_up: cover property (cfg_ack && cfg_addr == `PHIWD_UPPER_OFS);
    c_lo: cover property (cfg_ack && cfg_addr == `PHIWD_LOWER_OFS);
    c_en: cover property (cfg_req && cfg_wdata[15]);
endmodule

// >>> test/testbench.sv
`timescale 1ns/1ns
`include "phiwd_map.svh"

// ----------------------------------------------------------------------
// Bench: controller and hub joined by one carrier.
// ----------------------------------------------------------------------
module testbench;
    logic        clk = 1'b0, rst = 1'b1;            // Clock and reset.
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB request.
    logic [7:0]  paddr = 8'h00;                     // APB address.
    logic [31:0] pwdata = 32'h0, prdata, rd, ta = 32'h0; // Data and outbound address.
    logic        pready, pslverr, busy, locked, err; // Controller outputs.
    logic [1:0]  mode = 2'h1;                       // Mode strap.
    logic        peer = 1'b0, tv = 1'b0;            // Peer strap, outbound request.
    logic        dv, dp, dc, df, dn, live;          // Hub decision outputs.
    int          miscompares = 0, n_compared = 0, cyc = 0; // Counters.

    phiwd_link_if link ();
    phiwd_cfg_end phiwd_cfg_end_i (.clk(clk), .rst(rst), .link(link), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cfg_busy(busy), .cfg_locked(locked));
    phiwd_hub_end phiwd_hub_end_i (.clk(clk), .rst(rst), .link(link), .strap_mode(mode),
        .strap_is_peer(peer), .txn_valid(tv), .txn_addr(ta), .dec_valid(dv),
        .dec_to_peer(dp), .dec_claim_local(dc), .dec_forward_link(df), .dec_pass(dn),
        .win_live(live));
    phiwd_link_sva phiwd_link_sva_i (.clk(clk), .rst(rst), .cfg_req(link.cfg_req),
        .cfg_we(link.cfg_we), .cfg_addr(link.cfg_addr), .cfg_wdata(link.cfg_wdata),
        .cfg_ack(link.cfg_ack), .cfg_rdata(link.cfg_rdata));

    initial forever #50 clk = ~clk;

    // A hang counts as a mismatch; the ceiling is well above the few hundred cycles used.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask

    // One APB transfer; entered just after a rising edge, leaves one idle cycle.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clk);
    endtask

    // Straps are only caught under reset, so every strap change needs one.
    task automatic do_reset(input logic [1:0] m, input logic p, input int n);
        mode <= m; peer <= p; rst <= 1'b1;
        repeat (n) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask

    // One outbound request; the decision is looked at in the cycle after.
    task automatic probe(input logic [31:0] a, input logic hit);
        tv <= 1'b1; ta <= a;
        @(posedge clk);
        tv <= 1'b0;
        @(negedge clk);
        chk("decision", {27'h0, dv, dp, dc, df, dn},
            {27'h0, 1'b1, hit, hit & peer, hit & !peer, !hit});
        @(posedge clk);
    endtask

    // Programs a window, then probes both edges of it and the region prefix.
    task automatic run_case(input logic [1:0] m, input logic p, input logic [15:0] b,
                            input logic [15:0] l);
        logic        en;
        logic [31:0] a [5];
        en = (m == 2'h1) && b[15] && (b[11:0] <= l[11:0]);
        a = '{{12'hfec, b[11:0], 8'h00}, {12'hfec, b[11:0], 8'h00} - 32'h1,
              {12'hfec, l[11:0], 8'hff}, {12'hfec, l[11:0], 8'hff} + 32'h1,
              {12'hfed, b[11:0], 8'h40}};
        do_reset(m, p, 3);
        apb(1'b1, `PHIWD_A_BASE, {16'hffff, b | 16'h7000});
        apb(1'b1, `PHIWD_A_LIMIT, {16'hffff, l | 16'hf000});
        apb(1'b0, `PHIWD_A_BASE, 32'h0);
        chk("base", rd, {16'h0, b & `PHIWD_LOWER_WMASK});
        apb(1'b0, `PHIWD_A_LIMIT, 32'h0);
        chk("limit", rd, {16'h0, l & `PHIWD_UPPER_WMASK});
        apb(1'b1, `PHIWD_A_CTRL, 32'h1);
        chk("busy", {31'h0, busy}, 32'h1);
        while (locked !== 1'b1) @(posedge clk);
        @(posedge clk);
        @(negedge clk);
        chk("live", {30'h0, busy, live}, {30'h0, 1'b0, en});
        @(posedge clk);
        foreach (a[i]) probe(a[i], en && a[i][31:20] == `PHIWD_REGION
            && a[i][19:8] >= b[11:0] && a[i][19:8] <= l[11:0]);
    endtask

    task automatic t_regs();
        apb(1'b0, `PHIWD_A_RANGE, 32'h0);
        chk("range", rd, 32'h0fff_0000);
        apb(1'b1, `PHIWD_A_RANGE, 32'h0200_0100);
        apb(1'b1, `PHIWD_A_BASE, 32'h0000_8123);
        apb(1'b1, `PHIWD_A_LIMIT, 32'h0000_0345);
        apb(1'b1, `PHIWD_A_CTRL, 32'h1);
        apb(1'b0, `PHIWD_A_STAT, 32'h0);
        chk("span refused", rd, 32'h8);
        apb(1'b1, `PHIWD_A_CTRL, 32'h2);
        apb(1'b0, `PHIWD_A_STAT, 32'h0);
        chk("stat", rd, 32'h0);
        apb(1'b1, 8'h14, 32'h1);
        chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
    endtask

    task automatic t_forward(); run_case(2'h1, 1'b0, 16'h8123, 16'h0345); endtask
    task automatic t_claim(); run_case(2'h1, 1'b1, 16'h8010, 16'h0010); endtask
    task automatic t_off(); run_case(2'h1, 1'b0, 16'h0123, 16'h0345); endtask
    task automatic t_inverted(); run_case(2'h1, 1'b0, 16'h8400, 16'h0345); endtask

    // Every non-proxy strap leaves routing untouched.
    task automatic t_strap();
        run_case(2'h0, 1'b0, 16'h8123, 16'h0345);
        run_case(2'h2, 1'b1, 16'h8123, 16'h0345);
        run_case(2'h3, 1'b0, 16'h8123, 16'h0345);
    endtask

    // A second commit is refused and the window it tried to set never lands.
    task automatic t_lock();
        run_case(2'h1, 1'b0, 16'h8200, 16'h0300);
        apb(1'b1, `PHIWD_A_BASE, 32'h0000_8f00);
        apb(1'b1, `PHIWD_A_CTRL, 32'h1);
        repeat (8) @(posedge clk);
        apb(1'b0, `PHIWD_A_STAT, 32'h0);
        chk("stat lock", rd & 32'hc, 32'hc);
        probe(32'hfec2_0000, 1'b1);
    endtask

    initial begin
        do_reset(2'h1, 1'b0, 20);
        t_regs();
        t_forward();
        t_claim();
        t_off();
        t_inverted();
        t_strap();
        t_lock();
        complete_run();
    end
endmodule
